// ---- gpc_defs.svh ----
// register indices, field positions, reset values of the port block
// assumes: included by bare name wherever these constants are needed
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// word index of each register; byte address is four times the index
`define GPC_IDX_PORT 10'h106
`define GPC_IDX_INTCTL 10'h10b
`define GPC_IDX_OPTION 10'h181
`define GPC_IDX_DIR 10'h186
`define GPC_IDX_STAT 10'h200
`define GPC_IDX_MASK 10'h201

// option register fields
`define GPC_OPT_PU_BIT 7
`define GPC_OPT_EDGE_BIT 6
`define GPC_OPT_RST 8'hff

// direction register reset: all pins input
`define GPC_DIR_RST 8'hff

// interrupt control fields
`define GPC_IC_GIE_BIT 7
`define GPC_IC_XEN_BIT 4
`define GPC_IC_CEN_BIT 3
`define GPC_IC_XFL_BIT 1
`define GPC_IC_CFL_BIT 0
`define GPC_IC_MASK 8'h9b
`define GPC_IC_RST 8'h00

// event status and mask fields
`define GPC_ST_CHG_BIT 0
`define GPC_ST_EXT_BIT 1
`define GPC_ST_RST 2'h0

// lowest pin of the change-watch group
`define GPC_WATCH_LO 4

// edges after reset before the synchronised pins are trusted
`define GPC_SYNC_PRIME 2'h3

`endif

// ---- gpc_pkg.sv ----
// state types of the port block modules
// assumes: widths fixed at the documented eight pins
package gpc_pkg;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } gpc_sync_st_t;

  typedef struct packed {
    logic [1:0] prime;
    logic [3:0] snap;
  } gpc_chg_st_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] opt;
    logic [7:0] ic;
    logic [1:0] stat;
    logic [1:0] mask;
    logic pin0_prev;
    logic ack;
    logic [7:0] rdat;
    logic [7:0] oe;
    logic [7:0] pu;
    logic irq;
    logic wake;
  } gpc_top_st_t;

endpackage : gpc_pkg

// ---- gpc_chg_if.sv ----
// link between the port top and its change detector
// assumes: both ends on the same clock
`timescale 1ns/1ns
interface gpc_chg_if;
  logic [3:0] pins;
  logic [3:0] in_mask;
  logic refresh;
  logic [3:0] mismatch;
  logic any;

  modport ctl (output pins, output in_mask, output refresh,
    input mismatch, input any);
  modport det (input pins, input in_mask, input refresh,
    output mismatch, output any);
endinterface : gpc_chg_if

// ---- gpc_sync.sv ----
// two-stage synchroniser for the eight port pins
// assumes: pins are asynchronous to clk_i
`timescale 1ns/1ns
module gpc_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] d_i,
  output logic [7:0] q_o
);
  gpc_pkg::gpc_sync_st_t r;
  gpc_pkg::gpc_sync_st_t n;

  always_comb
  begin
    n = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign q_o = r.s2;
endmodule : gpc_sync

// ---- gpc_chg_det.sv ----
// change detector of the upper four port pins
// assumes: pins already synchronised, refresh is a one-cycle pulse
`timescale 1ns/1ns
`include "gpc_defs.svh"
module gpc_chg_det (
  input wire logic clk_i,
  input wire logic rst_i,
  gpc_chg_if.det chg
);
  gpc_pkg::gpc_chg_st_t r;
  gpc_pkg::gpc_chg_st_t n;
  logic [3:0] mis;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_pin
      // outputs never take part
      assign mis[i] = (r.prime == `GPC_SYNC_PRIME) & chg.in_mask[i] &
        (chg.pins[i] ^ r.snap[i]);
    end
  endgenerate

  always_comb
  begin
    n = r;
    // snapshot follows the pins until the synchroniser holds real levels
    if (chg.refresh || (r.prime != `GPC_SYNC_PRIME))
    begin
      n.snap = chg.pins;
    end
    if (r.prime != `GPC_SYNC_PRIME)
    begin
      n.prime = r.prime + 2'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign chg.mismatch = mis;
  assign chg.any = |mis;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_snap_refresh: assert property (
    chg.refresh |=> (r.snap == $past(chg.pins)) &&
      (!chg.any || (chg.pins != $past(chg.pins))))
    else $error("snapshot not refreshed by port access");

  a_output_excluded: assert property (
    (chg.mismatch & ~chg.in_mask) == 4'h0)
    else $error("output pin took part in change compare");
endmodule : gpc_chg_det

// ---- gpc_port.sv ----
// eight-pin port with change and edge interrupts, Wishbone slave
// assumes: classic Wishbone master on clk_i, pins asynchronous
`timescale 1ns/1ns
`include "gpc_defs.svh"

module gpc_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_en_o,
  output logic irq_o,
  output logic wake_o
);
  localparam gpc_pkg::gpc_top_st_t TOP_RST = '{
    latch: 8'h00,
    dir: `GPC_DIR_RST,
    opt: `GPC_OPT_RST,
    ic: `GPC_IC_RST,
    stat: `GPC_ST_RST,
    mask: `GPC_ST_RST,
    pin0_prev: 1'b0,
    ack: 1'b0,
    rdat: 8'h00,
    oe: 8'h00,
    pu: 8'h00,
    irq: 1'b0,
    wake: 1'b0
  };

  gpc_pkg::gpc_top_st_t r;
  gpc_pkg::gpc_top_st_t n;
  logic [7:0] pins_s;
  logic [9:0] idx;
  logic req;
  logic rd;
  logic wr;
  logic hit_port;
  logic hit_ic;
  logic hit_opt;
  logic hit_dir;
  logic hit_stat;
  logic hit_mask;
  logic ext_edge;
  logic [7:0] rval;
  logic [7:0] wval;

  gpc_chg_if chg ();

  gpc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_i),
    .q_o(pins_s)
  );

  gpc_chg_det u_chg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .chg(chg)
  );

  // bus decode; one request per handshake
  assign req = wb_cyc_i & wb_stb_i & ~r.ack;
  assign rd = req & ~wb_we_i;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[11:2];
  assign wval = wb_dat_i[7:0];
  assign hit_port = (idx == `GPC_IDX_PORT);
  assign hit_ic = (idx == `GPC_IDX_INTCTL);
  assign hit_opt = (idx == `GPC_IDX_OPTION);
  assign hit_dir = (idx == `GPC_IDX_DIR);
  assign hit_stat = (idx == `GPC_IDX_STAT);
  assign hit_mask = (idx == `GPC_IDX_MASK);

  // change watch on the upper nibble, inputs only
  assign chg.pins = pins_s[7:`GPC_WATCH_LO];
  assign chg.in_mask = r.dir[7:`GPC_WATCH_LO];
  assign chg.refresh = req & hit_port;

  // pin 0 edge, polarity from option bit 6
  assign ext_edge = r.opt[`GPC_OPT_EDGE_BIT] ?
    (pins_s[0] & ~r.pin0_prev) :
    (~pins_s[0] & r.pin0_prev);

  always_comb
  begin
    rval = 8'h00;
    case (1'b1)
      hit_port: rval = pins_s;
      hit_ic: rval = r.ic & `GPC_IC_MASK;
      hit_opt: rval = r.opt;
      hit_dir: rval = r.dir;
      hit_stat: rval = {6'h00, r.stat};
      hit_mask: rval = {6'h00, r.mask};
      default: rval = 8'h00;
    endcase
  end

  always_comb
  begin
    n = r;
    n.ack = req;
    n.rdat = rd ? rval : 8'h00;
    n.pin0_prev = pins_s[0];
    if (wr && hit_port)
    begin
      n.latch = wval;
    end
    if (wr && hit_dir)
    begin
      n.dir = wval;
    end
    if (wr && hit_opt)
    begin
      n.opt = wval;
    end
    if (wr && hit_ic)
    begin
      n.ic = wval & `GPC_IC_MASK;
    end
    if (wr && hit_mask)
    begin
      n.mask = wval[1:0];
    end
    // hardware set beats a software clear in the same cycle
    if (chg.any)
    begin
      n.ic[`GPC_IC_CFL_BIT] = 1'b1;
    end
    if (ext_edge)
    begin
      n.ic[`GPC_IC_XFL_BIT] = 1'b1;
    end
    // event status: cleared by its read, set wins
    if (rd && hit_stat)
    begin
      n.stat = 2'h0;
    end
    if (chg.any)
    begin
      n.stat[`GPC_ST_CHG_BIT] = 1'b1;
    end
    if (ext_edge)
    begin
      n.stat[`GPC_ST_EXT_BIT] = 1'b1;
    end
    n.oe = ~n.dir;
    n.pu = {8{~n.opt[`GPC_OPT_PU_BIT]}} & n.dir;
    n.irq = (n.ic[`GPC_IC_GIE_BIT] &
      ((n.ic[`GPC_IC_CFL_BIT] & n.ic[`GPC_IC_CEN_BIT]) |
      (n.ic[`GPC_IC_XFL_BIT] & n.ic[`GPC_IC_XEN_BIT]))) |
      (|(n.stat & n.mask));
    // wake needs only the local enable, not global
    n.wake = n.ic[`GPC_IC_CFL_BIT] & n.ic[`GPC_IC_CEN_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= TOP_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = {24'h000000, r.rdat};
  assign pin_o = r.latch;
  assign pin_oe_o = r.oe;
  assign pullup_en_o = r.pu;
  assign irq_o = r.irq;
  assign wake_o = r.wake;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_port_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit_port;
  endsequence

  sequence s_port_write;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o &&
      hit_port;
  endsequence

  sequence s_rise_pin0;
    r.opt[`GPC_OPT_EDGE_BIT] && pins_s[0] && !$past(pins_s[0]);
  endsequence

  sequence s_fall_pin0;
    !r.opt[`GPC_OPT_EDGE_BIT] && !pins_s[0] && $past(pins_s[0]);
  endsequence

  a_dir_drive: assert property (
    pin_oe_o == ~r.dir)
    else $error("pin enable does not follow direction");

  a_pullup_gate: assert property (
    pullup_en_o == ({8{~r.opt[`GPC_OPT_PU_BIT]}} & r.dir))
    else $error("pull-up enable wrong");

  a_reset_state: assert property (
    $past(rst_i) |-> r.opt == `GPC_OPT_RST && pullup_en_o == 8'h00 &&
      pin_oe_o == 8'h00)
    else $error("reset values wrong");

  a_port_read: assert property (
    s_port_read |=> wb_ack_o && wb_dat_o[7:0] == $past(pins_s))
    else $error("port read data wrong");

  a_port_write: assert property (
    s_port_write |=> ##1 pin_o == $past(wb_dat_i[7:0], 2))
    else $error("port write not on pins");

  a_change_flag: assert property (
    chg.any |=> r.ic[`GPC_IC_CFL_BIT] && r.stat[`GPC_ST_CHG_BIT])
    else $error("mismatch did not set change flag");

  a_edge_flag: assert property (
    s_rise_pin0 ##0 !$past(rst_i) |=> r.ic[`GPC_IC_XFL_BIT])
    else $error("selected edge did not set flag");

  a_irq_cause: assert property (
    irq_o |-> (r.ic[`GPC_IC_GIE_BIT] &&
      ((r.ic[`GPC_IC_CFL_BIT] && r.ic[`GPC_IC_CEN_BIT]) ||
      (r.ic[`GPC_IC_XFL_BIT] && r.ic[`GPC_IC_XEN_BIT]))) ||
      (r.stat & r.mask) != 2'h0)
    else $error("interrupt without cause");

  a_wake_follow: assert property (
    wake_o == (r.ic[`GPC_IC_CFL_BIT] && r.ic[`GPC_IC_CEN_BIT]))
    else $error("wake does not follow change flag");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // bus handshake
  a_ack_answer: assert property (
    req |=> wb_ack_o)
    else $error("request not answered next cycle");

  a_ack_idle: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  a_idle_data: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");

  a_unmapped_zero: assert property (
    rd && !(hit_port || hit_ic || hit_opt || hit_dir || hit_stat ||
      hit_mask) |=> wb_dat_o == 32'h0)
    else $error("unmapped read returned data");

  // register writes
  a_dir_write: assert property (
    wr && hit_dir |=> pin_oe_o == ~$past(wb_dat_i[7:0]))
    else $error("direction write not applied");

  a_opt_write: assert property (
    wr && hit_opt |=> r.opt == $past(wb_dat_i[7:0]))
    else $error("option write not applied");

  a_ic_write: assert property (
    wr && hit_ic && !chg.any && !ext_edge |=>
      r.ic == ($past(wb_dat_i[7:0]) & `GPC_IC_MASK))
    else $error("interrupt control write not applied");

  a_mask_write: assert property (
    wr && hit_mask |=> r.mask == $past(wb_dat_i[1:0]))
    else $error("mask write not applied");

  a_latch_hold: assert property (
    !(wr && hit_port) |=> $stable(pin_o))
    else $error("output latch changed without port write");

  // pin path
  a_sync_delay: assert property (
    !$past(rst_i) && !$past(rst_i, 2) |-> pins_s == $past(pin_i, 2))
    else $error("pin level not two cycles through synchroniser");

  // event flags
  a_change_quiet: assert property (
    !chg.any && !r.ic[`GPC_IC_CFL_BIT] && !(wr && hit_ic) |=>
      !r.ic[`GPC_IC_CFL_BIT])
    else $error("change flag set without mismatch");

  a_edge_fall: assert property (
    s_fall_pin0 ##0 !$past(rst_i) |=> r.ic[`GPC_IC_XFL_BIT])
    else $error("falling edge did not set flag");

  a_edge_quiet: assert property (
    !ext_edge && !r.ic[`GPC_IC_XFL_BIT] && !(wr && hit_ic) |=>
      !r.ic[`GPC_IC_XFL_BIT])
    else $error("ext flag set without selected edge");

  a_ext_hold: assert property (
    r.ic[`GPC_IC_XFL_BIT] && !(wr && hit_ic) |=> r.ic[`GPC_IC_XFL_BIT])
    else $error("ext flag dropped without software clear");

  a_stat_set: assert property (
    ext_edge |=> r.stat[`GPC_ST_EXT_BIT])
    else $error("edge did not set status");

  a_stat_clear: assert property (
    rd && hit_stat && !chg.any && !ext_edge |=> r.stat == 2'h0)
    else $error("status read did not clear");

  // interrupt output
  a_irq_raise: assert property (
    (r.ic[`GPC_IC_GIE_BIT] && r.ic[`GPC_IC_CFL_BIT] &&
      r.ic[`GPC_IC_CEN_BIT]) |-> irq_o)
    else $error("enabled change flag without interrupt");

  a_irq_status: assert property (
    (r.stat & r.mask) != 2'h0 |-> irq_o)
    else $error("unmasked status without interrupt");
endmodule : gpc_port

// ---- gpc_pin_model.sv ----
// far-side pin model: keypad drivers, pull-ups, floating pins
// assumes: testbench commands which pins it drives and to what level
`timescale 1ns/1ns
module gpc_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] val_i,
  input wire logic [7:0] dev_out_i,
  input wire logic [7:0] dev_oe_i,
  input wire logic [7:0] dev_pu_i,
  output logic [7:0] lvl_o
);
  logic [7:0] float_r = 8'h55;

  // undriven pin without pull-up wanders every cycle
  always @(posedge clk_i)
  begin
    float_r <= ~float_r;
  end

  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      if (dev_oe_i[k])
        lvl_o[k] = dev_out_i[k];
      else if (drv_i[k])
        lvl_o[k] = val_i[k];
      else if (dev_pu_i[k])
        lvl_o[k] = 1'b1;
      else
        lvl_o[k] = float_r[k];
    end
  end
endmodule : gpc_pin_model

// ---- tb_gpc_port.sv ----
// self-checking bench of the eight-pin port block
// assumes: design files compiled first, one 250 MHz clock
`timescale 1ns/1ns
module tb_gpc_port;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h1;
  logic [31:0] rd;
  logic [7:0] drv = 8'hff;
  logic [7:0] val = 8'h30;
  logic [31:0] dat_o;
  logic ack, irq, wake;
  logic [7:0] po, oe, pu, lvl;
  int n_fail = 0;
  int check_count = 0;

  gpc_port u_gpc_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_i(lvl),
    .pin_o(po), .pin_oe_o(oe), .pullup_en_o(pu), .irq_o(irq),
    .wake_o(wake));
  gpc_pin_model u_gpc_pin_model (.clk_i(clk_i), .drv_i(drv),
    .val_i(val), .dev_out_i(po), .dev_oe_i(oe), .dev_pu_i(pu),
    .lvl_o(lvl));

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic cycle; ack and read data taken at a rising edge
  task automatic bus(input logic w, input logic [9:0] idx,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    if (n >= 20)
    begin
      n_fail++;
      end_sim();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask : wait_irq

  task automatic settle();
    repeat (6) @(negedge clk_i);
  endtask : settle

  task automatic t_reset();
    bus(0, 10'h181, 8'h0);
    chk("option", rd, 32'hff);
    bus(0, 10'h186, 8'h0);
    chk("direction", rd, 32'hff);
    bus(0, 10'h10b, 8'h0);
    chk("intctl", rd, 32'h0);
    chk("oe", oe, 32'h0);
    chk("pullup", pu, 32'h0);
  endtask : t_reset

  task automatic t_drive();
    bus(1, 10'h186, 8'hf0);
    bus(1, 10'h106, 8'ha5);
    @(negedge clk_i);
    chk("oe", oe, 32'h0f);
    chk("pin_o", po, 32'ha5);
    bus(0, 10'h106, 8'h0);
    chk("port read", rd, 32'h35);
    bus(1, 10'h181, 8'h7f);
    @(negedge clk_i);
    chk("pullup", pu, 32'hf0);
    bus(1, 10'h181, 8'hff);
    @(negedge clk_i);
    chk("pullup", pu, 32'h0);
  endtask : t_drive

  // port read only to take the snapshot, port writes end the mismatch; never polled
  task automatic t_change();
    bus(1, 10'h186, 8'hff);
    bus(1, 10'h10b, 8'h88);
    bus(0, 10'h106, 8'h0);
    @(posedge clk_i);
    val <= 8'h10;
    wait_irq();
    chk("wake", wake, 32'h1);
    bus(0, 10'h10b, 8'h0);
    chk("chg flag", rd, 32'h89);
    bus(1, 10'h10b, 8'h88);
    bus(0, 10'h10b, 8'h0);
    chk("chg sticks", rd, 32'h89);
    bus(1, 10'h106, 8'h00);
    bus(1, 10'h10b, 8'h88);
    @(negedge clk_i);
    chk("irq", irq, 32'h0);
    chk("wake off", wake, 32'h0);
    bus(1, 10'h186, 8'h7f);
    bus(1, 10'h106, 8'h80);
    settle();
    bus(0, 10'h10b, 8'h0);
    chk("excluded", rd, 32'h88);
  endtask : t_change

  task automatic t_edge();
    logic e;
    bus(1, 10'h186, 8'hff);
    bus(1, 10'h10b, 8'h90);
    for (int i = 0; i < 2; i++)
    begin
      e = (i == 0);
      bus(1, 10'h181, e ? 8'hff : 8'hbf);
      val[0] <= ~e;
      settle();
      bus(1, 10'h10b, 8'h90);
      val[0] <= e;
      wait_irq();
      bus(0, 10'h10b, 8'h0);
      chk("ext flag", rd, 32'h92);
      settle();
      bus(0, 10'h10b, 8'h0);
      chk("ext holds", rd, 32'h92);
      bus(1, 10'h10b, 8'h90);
      val[0] <= ~e;
      settle();
      bus(0, 10'h10b, 8'h0);
      chk("wrong edge", rd, 32'h90);
    end
  endtask : t_edge

  task automatic t_status();
    bus(0, 10'h200, 8'h0);
    bus(0, 10'h200, 8'h0);
    chk("status clr", rd, 32'h0);
    bus(1, 10'h10b, 8'h00);
    bus(1, 10'h201, 8'h02);
    val[0] <= 1'b0;
    wait_irq();
    bus(0, 10'h200, 8'h0);
    chk("status", rd, 32'h2);
    @(negedge clk_i);
    chk("irq off", irq, 32'h0);
    bus(0, 10'h3ff, 8'h0);
    chk("unmapped", rd, 32'h0);
    sel <= 4'h0;
    bus(1, 10'h201, 8'h00);
    sel <= 4'h1;
    bus(0, 10'h201, 8'h0);
    chk("sel ignored", rd, 32'h2);
  endtask : t_status

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_drive();
    t_change();
    t_edge();
    t_status();
    end_sim();
  end
endmodule : tb_gpc_port
